// ==== design/asr_host.sv ====
// host controller for an asynchronous 1M x 4 static memory
// Functional notes
// - data held valid until write-ending edge
// - wait one microsecond before first access
// - address set on the same clock edge that select falls
// - host drivers off while device drives
// - write long enough for turnoff plus setup
`timescale 1ns/100ps
`default_nettype none
module asr_host #(
  parameter int ADDR_W = asr_pkg::ADDR_W,
  parameter int DATA_W = asr_pkg::DATA_W,
  parameter int POWER_CYC = asr_pkg::T_POWER_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // user request port
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DATA_W-1:0] rd_data_out,
  // memory pins
  output logic chip_sel_n_out,
  output logic out_en_n_out,
  output logic wr_strobe_n_out,
  output logic [ADDR_W-1:0] word_address_out,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic [DATA_W-1:0] data_lines_in
);
  asr_pkg::asr_ctl_t s_q;
  asr_pkg::asr_ctl_t s_d;
  logic tmr_load;
  logic [asr_pkg::CNT_W-1:0] tmr_val;
  logic tmr_done;
  logic [asr_pkg::CNT_W-1:0] pwr_cnt_q;
  logic pwr_done_q;

  // the power-up count gets its own counter, as wide (CNT_W bits) as the shared timer
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      pwr_cnt_q <= '0;
      pwr_done_q <= 1'b0;
    end
    else if (!pwr_done_q)
    begin
      pwr_cnt_q <= pwr_cnt_q + 1'b1;
      if (int'(pwr_cnt_q) >= POWER_CYC - 1)
        pwr_done_q <= 1'b1;
    end
  end

  asr_delay_cnt #(.W(asr_pkg::CNT_W)) u_tmr (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(tmr_load),
    .value_in(tmr_val),
    .done_out(tmr_done)
  );

  // next-state logic; pins change at state boundaries (data_lines_oe drops one cycle into RECOVER), so address and select change on the same edge
  always_comb
  begin
    s_d = s_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    s_d.rd_valid = 1'b0;
    unique case (s_q.st)
      asr_pkg::ASR_ST_POWER:
      begin
        if (pwr_done_q)
        begin
          s_d.st = asr_pkg::ASR_ST_IDLE;
          s_d.ready = 1'b1;
        end
      end
      asr_pkg::ASR_ST_IDLE:
      begin
        if (req_valid_in)
        begin
          s_d.ready = 1'b0;
          s_d.is_wr = req_write_in;
          s_d.pins.word_address = req_addr_in[asr_pkg::ADDR_W-1:0];
          s_d.pins.chip_sel_n = 1'b0;
          tmr_load = 1'b1;
          if (req_write_in)
          begin
            // output enable stays high on writes so the device never drives
            s_d.pins.out_en_n = 1'b1;
            s_d.pins.wr_strobe_n = 1'b0;
            s_d.pins.data_lines_o = req_wdata_in[asr_pkg::DATA_W-1:0];
            s_d.pins.data_lines_oe = 1'b1;
            tmr_val = asr_pkg::CNT_W'(asr_pkg::T_PWE_CYC);
            s_d.st = asr_pkg::ASR_ST_WRITE;
          end
          else
          begin
            s_d.pins.wr_strobe_n = 1'b1;
            s_d.pins.out_en_n = 1'b0;
            s_d.pins.data_lines_oe = 1'b0;
            tmr_val = asr_pkg::CNT_W'(asr_pkg::T_ACC_CYC);
            s_d.st = asr_pkg::ASR_ST_READ;
          end
        end
      end
      asr_pkg::ASR_ST_READ:
      begin
        if (tmr_done)
        begin
          s_d.rd_data = data_lines_in[asr_pkg::DATA_W-1:0];
          s_d.rd_valid = 1'b1;
          s_d.pins.chip_sel_n = 1'b1;
          s_d.pins.out_en_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = asr_pkg::CNT_W'(asr_pkg::T_HZ_CYC);
          s_d.st = asr_pkg::ASR_ST_RECOVER;
        end
      end
      asr_pkg::ASR_ST_WRITE:
      begin
        if (tmr_done)
        begin
          // both strobes rise together; data is held one more clock cycle for hold
          s_d.pins.chip_sel_n = 1'b1;
          s_d.pins.wr_strobe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = asr_pkg::CNT_W'(1);
          s_d.st = asr_pkg::ASR_ST_RECOVER;
        end
      end
      asr_pkg::ASR_ST_RECOVER:
      begin
        s_d.pins.data_lines_oe = 1'b0;
        if (tmr_done)
        begin
          s_d.ready = 1'b1;
          s_d.st = asr_pkg::ASR_ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = asr_pkg::ASR_ST_IDLE;
      end
    endcase
  end

  // single state register; reset puts pins in the idle, deselected level
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      s_q <= '0;
      s_q.st <= asr_pkg::ASR_ST_POWER;
      s_q.pins.chip_sel_n <= 1'b1;
      s_q.pins.out_en_n <= 1'b1;
      s_q.pins.wr_strobe_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign req_ready_out = s_q.ready;
  assign rd_valid_out = s_q.rd_valid;
  assign rd_data_out = s_q.rd_data;
  assign chip_sel_n_out = s_q.pins.chip_sel_n;
  assign out_en_n_out = s_q.pins.out_en_n;
  assign wr_strobe_n_out = s_q.pins.wr_strobe_n;
  assign word_address_out = s_q.pins.word_address;
  assign data_lines_out = s_q.pins.data_lines_o;
  assign data_lines_oe_out = s_q.pins.data_lines_oe;

  property p_no_access_before_power;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      !pwr_done_q |-> chip_sel_n_out;
  endproperty
  a_no_access_before_power: assert property (p_no_access_before_power) else $error("access before power-up wait");

  property p_no_contention;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      data_lines_oe_out |-> out_en_n_out;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("host drives while output enabled");

  property p_addr_stable_selected;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (!chip_sel_n_out && !$past(chip_sel_n_out)) |-> $stable(word_address_out);
  endproperty
  a_addr_stable_selected: assert property (p_addr_stable_selected) else $error("address moved while selected");

  property p_write_width;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      $fell(wr_strobe_n_out) |-> (!wr_strobe_n_out && !chip_sel_n_out && data_lines_oe_out)[*3] ##1 wr_strobe_n_out;
  endproperty
  a_write_width: assert property (p_write_width) else $error("write pulse width wrong");

  property p_data_hold;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(wr_strobe_n_out) |-> data_lines_oe_out && $rose(chip_sel_n_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held past write end");

  property p_read_strobe_high;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      !out_en_n_out |-> wr_strobe_n_out && !chip_sel_n_out;
  endproperty
  a_read_strobe_high: assert property (p_read_strobe_high) else $error("read with write strobe low");

  property p_read_result;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      $fell(out_en_n_out) |-> ##3 rd_valid_out;
  endproperty
  a_read_result: assert property (p_read_result) else $error("read result late");

  property p_release_after_write;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(wr_strobe_n_out) |=> !data_lines_oe_out;
  endproperty
  a_release_after_write: assert property (p_release_after_write) else $error("data drive not released");
endmodule
`default_nettype wire

// ==== design/asr_pkg.sv ====
// shared constants and carrier types for the static memory host controller
package asr_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 4;
  localparam int CLK_PERIOD_PS = 8000;
  // power-up wait before first access, in ns
  localparam int T_POWER_NS = 1000;
  localparam int T_POWER_CYC = (T_POWER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // read access from address or select, in ns (longest speed grade)
  localparam int T_ACC_NS = 15;
  localparam int T_ACC_CYC = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // write pulse width, in ns
  localparam int T_PWE_NS = 10;
  localparam int T_PWE_CYC = (T_PWE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // output turn-off after strobes rise, in ns
  localparam int T_HZ_NS = 7;
  localparam int T_HZ_CYC = (T_HZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    ASR_ST_POWER = 3'b000,
    ASR_ST_IDLE = 3'b001,
    ASR_ST_READ = 3'b010,
    ASR_ST_WRITE = 3'b011,
    ASR_ST_RECOVER = 3'b100
  } asr_state_t;

  // memory-side pins driven by the host
  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic wr_strobe_n;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] data_lines_o;
    logic data_lines_oe;
  } asr_pins_t;

  typedef struct packed {
    asr_state_t st;
    logic [CNT_W-1:0] cnt;
    logic is_wr;
    asr_pins_t pins;
    logic ready;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
  } asr_ctl_t;
endpackage

// ==== design/asr_delay_cnt.sv ====
// loadable down counter used to time every phase of the access
`timescale 1ns/100ps
`default_nettype none
module asr_delay_cnt #(
  parameter int W = 8
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);
  logic [W-1:0] cnt_q;
  // counts down to zero and holds; reset leaves it expired
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      cnt_q <= '0;
    else if (load_in)
      cnt_q <= value_in;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end
  assign done_out = (cnt_q == '0);
endmodule
`default_nettype wire

// ==== sim/asr_mem_model.sv ====
// behavioural model of the static memory on the far side of the host
`timescale 1ns/100ps
`default_nettype none
module asr_mem_model (
  input wire logic chip_sel_n_in,
  input wire logic out_en_n_in,
  input wire logic wr_strobe_n_in,
  input wire logic [asr_pkg::ADDR_W-1:0] word_address_in,
  input wire logic [asr_pkg::DATA_W-1:0] wire_in,
  output logic [asr_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out
);
  // sparse store of 1M four-bit words; unwritten words read as zero
  logic [asr_pkg::DATA_W-1:0] mem_q [logic [asr_pkg::ADDR_W-1:0]];
  // level write: stores all through the overlap, so the value at the ending edge wins
  always @*
  begin
    if (!chip_sel_n_in && !wr_strobe_n_in)
      mem_q[word_address_in] = wire_in;
  end
  // drive only in a plain read; standby and writes keep the lines floating
  assign data_lines_oe_out = !chip_sel_n_in && !out_en_n_in && wr_strobe_n_in;
  // reads never touch the store; strobes in the list so a read right after a write sees the new word
  always @(word_address_in or chip_sel_n_in or out_en_n_in or wr_strobe_n_in)
  begin
    data_lines_out = mem_q.exists(word_address_in) ? mem_q[word_address_in] : 4'h0;
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int POWER_CYC = 4;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [19:0] req_addr = 20'h0_0000;
  logic [3:0] req_wdata = 4'h0;
  logic ready, rd_valid, cs_n, oe_n, we_n, h_oe, m_oe, prev_we, prev_cs;
  logic [3:0] rd_data, h_data, m_data, dq, float_pat = 4'h0;
  logic [19:0] addr_pin, exp_addr;
  logic [3:0] shadow [logic [19:0]];
  int fail_count = 0;
  int n_compared = 0;
  int n;
  logic [19:0] a;

  asr_host #(.POWER_CYC(POWER_CYC)) i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_ready_out(ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data), .chip_sel_n_out(cs_n),
    .out_en_n_out(oe_n), .wr_strobe_n_out(we_n), .word_address_out(addr_pin), .data_lines_out(h_data),
    .data_lines_oe_out(h_oe), .data_lines_in(dq));
  asr_mem_model i_mem (.chip_sel_n_in(cs_n), .out_en_n_in(oe_n), .wr_strobe_n_in(we_n),
    .word_address_in(addr_pin), .wire_in(dq), .data_lines_out(m_data), .data_lines_oe_out(m_oe));

  // released lines show a pattern that changes each cycle, not a held value
  assign dq = h_oe ? h_data : (m_oe ? m_data : float_pat);
  initial
  begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) float_pat <= float_pat + 4'h5;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [3:0] exp_of(input logic [19:0] adr);
    return shadow.exists(adr) ? shadow[adr] : 4'h0;
  endfunction

  // pin watch at the falling edge, where registered outputs have settled
  always @(negedge ref_clk_in)
  begin
    if (!sys_rst_in)
    begin
      check("contention", {31'h0, h_oe & m_oe}, 32'h0);
      if (ready === 1'b1)
        check("idle_select", {29'h0, cs_n, oe_n, we_n}, 32'h7);
      if (prev_we === 1'b0 && we_n === 1'b1)
        check("data_held_at_write_end", {31'h0, h_oe}, 32'h1);
      if (prev_cs === 1'b1 && cs_n === 1'b0)
        check("address_at_select", {12'h0, addr_pin}, {12'h0, exp_addr});
    end
    prev_we <= we_n;
    prev_cs <= cs_n;
  end

  // one request, then a refused one while busy, then the read-back compare on reads
  task automatic access(input logic wr, input logic [19:0] adr, input logic [3:0] d);
    int k;
    k = 0;
    while (ready !== 1'b1)
    begin
      @(negedge ref_clk_in);
      k++;
      if (k > 60)
      begin
        fail_count++;
        finish_test();
      end
    end
    @(posedge ref_clk_in);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= adr;
    req_wdata <= d;
    exp_addr = adr;
    // take edge: the request is sampled here, a changed one then stands while busy
    @(posedge ref_clk_in);
    req_write <= 1'b1;
    req_addr <= adr ^ 20'h0_0001;
    req_wdata <= ~d;
    @(negedge ref_clk_in);
    check("taken", {31'h0, ready}, 32'h0);
    @(posedge ref_clk_in);
    req_valid <= 1'b0;
    if (wr)
      shadow[adr] = d;
    else
    begin
      k = 0;
      while (rd_valid !== 1'b1)
      begin
        @(negedge ref_clk_in);
        k++;
        if (k > 20)
        begin
          fail_count++;
          finish_test();
        end
      end
      check("read_latency", k, asr_pkg::T_ACC_CYC + 1);
      check("read_data", {28'h0, rd_data}, {28'h0, exp_of(adr)});
    end
  endtask

  initial
  begin
    void'($urandom(10714));
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    check("power_wait", {31'h0, n > POWER_CYC && n < 200}, 32'h1);
    access(1'b1, 20'h0_0000, 4'hA);
    access(1'b1, 20'hF_FFFF, 4'h5);
    access(1'b0, 20'h0_0000, 4'h0);
    access(1'b0, 20'h0_0001, 4'h0);
    access(1'b0, 20'hF_FFFF, 4'h0);
    access(1'b0, 20'hF_FFFF, 4'h0);
    for (int i = 0; i < 40; i++)
    begin
      a = 20'($urandom & 32'h7) | ((i % 2) ? 20'hF_FFF8 : 20'h0_0000);
      access(1'($urandom), a, 4'($urandom));
    end
    finish_test();
  end
endmodule
`default_nettype wire
